//--- src/dram_array_pkg.sv
`default_nettype none
package dram_array_pkg;
   // ************************************************************
   // Array geometry
   // ************************************************************
   localparam int ROW_WIDTH  = 6;
   localparam int COL_WIDTH  = 6;
   localparam int ADDR_WIDTH = ROW_WIDTH + COL_WIDTH;
   localparam int ROW_COUNT  = 64;
   localparam int COL_COUNT  = 64;
   localparam int ROW_LSB    = 0;
   localparam int COL_LSB    = 6;
   localparam int HALF_BIT   = 5;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLOCK_PERIOD_NS = 25;
   // Charge sharing settles before the strobe (least time, rounds up)
   localparam int SHARE_TIME_NS   = 75;
   localparam int SHARE_CYCLES    =
      (SHARE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   // Longest access time (rounds down)
   localparam int ACCESS_TIME_NS  = 300;
   localparam int ACCESS_CYCLES   = ACCESS_TIME_NS / CLOCK_PERIOD_NS;
   // Least complete cycle (rounds up)
   localparam int CYCLE_TIME_NS   = 470;
   localparam int CYCLE_CYCLES    =
      (CYCLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int REFRESH_TIME_NS = 2000000;
   localparam int REFRESH_CYCLES  = REFRESH_TIME_NS / CLOCK_PERIOD_NS;

   localparam int TIMER_WIDTH     = 5;
   localparam int REFRESH_WIDTH   = 17;

   localparam logic [TIMER_WIDTH-1:0] TIMER_ZERO = 5'h00;
   localparam logic [TIMER_WIDTH-1:0] TIMER_ONE  = 5'h01;
   localparam logic [ROW_WIDTH-1:0]   ROW_ZERO   = 6'h00;
   localparam logic [COL_WIDTH-1:0]   COL_ZERO   = 6'h00;
   localparam logic [COL_COUNT-1:0]   LINE_ZERO  = 64'h0;
   localparam logic [ROW_COUNT-1:0]   ALL_ROWS   = 64'hFFFFFFFFFFFFFFFF;

   // ************************************************************
   // Access phases
   // ************************************************************
   typedef enum logic [2:0] {
      PHASE_PRECHARGE,
      PHASE_SHARE,
      PHASE_SENSE,
      PHASE_RESTORE,
      PHASE_HOLD
   } phase_t;
endpackage
`default_nettype wire

//--- src/sense_bus_if.sv
`default_nettype none
// Links the array core to its bank of column sense amplifiers
interface sense_bus_if;
   logic [dram_array_pkg::COL_COUNT-1:0] row_bits;
   logic [dram_array_pkg::COL_WIDTH-1:0] column;
   logic                                 write_en;
   logic                                 data_in;
   logic                                 equalize;
   logic                                 strobe;
   logic [dram_array_pkg::COL_COUNT-1:0] restored;
   logic                                 balanced;

   modport array (
      output row_bits, column, write_en, data_in, equalize, strobe,
      input  restored, balanced
   );
   modport amps (
      input  row_bits, column, write_en, data_in, equalize, strobe,
      output restored, balanced
   );
endinterface
`default_nettype wire

//--- src/column_sense_bank.sv
`default_nettype none
// ************************************************************
// One differential latch per column
// ************************************************************
module column_sense_bank (
   input  wire logic     clock,
   input  wire logic     rst,
   sense_bus_if.amps     bus
);
   logic [dram_array_pkg::COL_COUNT-1:0] hit;
   logic [dram_array_pkg::COL_COUNT-1:0] latch;
   logic                                 balanced;

   genvar i;
   generate
      for (i = 0; i < dram_array_pkg::COL_COUNT; i++) begin : g_col
         localparam int unsigned COL_ID = i;
         // Only the decoded column is overdriven by data-in
         assign hit[i] = bus.write_en &&
            (bus.column == COL_ID[dram_array_pkg::COL_WIDTH-1:0]);
         // Latch resolves on the strobe; equalize discharges it
         always_ff @(posedge clock) begin
            if (rst || bus.equalize) begin
               latch[i] <= 1'b0;
            end else if (bus.strobe) begin
               latch[i] <= hit[i] ? bus.data_in : bus.row_bits[i];
            end
         end
      end
   endgenerate

   // Balanced means both column halves sit equal, nothing resolved
   always_ff @(posedge clock) begin
      if (rst || bus.equalize) begin
         balanced <= 1'b1;
      end else if (bus.strobe) begin
         balanced <= 1'b0;
      end
   end

   assign bus.restored = latch;
   assign bus.balanced = balanced;
endmodule
`default_nettype wire

//--- src/dynamic_ram_4k_array_core.sv
`default_nettype none
// How it works
// - Holds 4096 one-bit words; a 12-bit address picks the bit.
// - Address and chip select are registered at the access start.
// - Cells form 64 by 64; low six bits pick row, high six column.
// - Chip-enable low equalizes column halves; dummy cells sit midway.
// - Chip-enable rise takes addresses, opens row and opposite dummy row.
// - After the strobe all 64 amplifiers resolve and restore the whole row.
// - On a read the chosen column reaches the output buffer after sensing.
// - On a write data-in overdrives the chosen amplifier into the cell.
module dynamic_ram_4k_array_core #(
   parameter int REFRESH_LIMIT = dram_array_pkg::REFRESH_CYCLES
) (
   input  wire logic                                  clock,
   input  wire logic                                  rst,
   input  wire logic                                  chip_enable,
   input  wire logic                                  chip_select,
   input  wire logic                                  read_write,
   input  wire logic [dram_array_pkg::ADDR_WIDTH-1:0] address,
   input  wire logic                                  data_in,
   output var  logic                                  data_out,
   output var  logic                                  data_valid,
   output var  logic                                  sense_latch_strobe,
   output var  logic                                  precharging,
   output var  logic [dram_array_pkg::ROW_WIDTH-1:0]  active_row,
   output var  logic                                  dummy_half,
   output var  logic                                  short_cycle,
   output var  logic                                  refresh_missed
);
   // ************************************************************
   // Storage and captured request
   // ************************************************************
   logic [dram_array_pkg::COL_COUNT-1:0] cells [dram_array_pkg::ROW_COUNT];
   dram_array_pkg::phase_t               phase;
   dram_array_pkg::phase_t               next_phase;
   logic                                 enable_prev;
   logic [dram_array_pkg::ROW_WIDTH-1:0] row_address_bits;
   logic [dram_array_pkg::COL_WIDTH-1:0] column_address_bits;
   logic                                 selected;
   logic                                 writing;
   logic [dram_array_pkg::TIMER_WIDTH-1:0] timer;
   logic [dram_array_pkg::TIMER_WIDTH-1:0] cycle_age;
   logic [dram_array_pkg::REFRESH_WIDTH-1:0] refresh_timer;
   logic [dram_array_pkg::ROW_COUNT-1:0] rows_seen;

   sense_bus_if bus ();

   column_sense_bank amps (
      .clock (clock),
      .rst   (rst),
      .bus   (bus)
   );

   // ************************************************************
   // Decode
   // ************************************************************
   wire enable_rise = chip_enable && !enable_prev;
   wire enable_fall = !chip_enable && enable_prev;
   wire share_done  = (timer == dram_array_pkg::TIMER_ONE);
   wire [dram_array_pkg::ROW_WIDTH-1:0] take_row =
      address[dram_array_pkg::ROW_LSB +: dram_array_pkg::ROW_WIDTH];
   wire [dram_array_pkg::COL_WIDTH-1:0] take_col =
      address[dram_array_pkg::COL_LSB +: dram_array_pkg::COL_WIDTH];
   // Restore only from a resolved latch, never from a balanced one
   wire restore_now  = (phase == dram_array_pkg::PHASE_RESTORE) &&
                       !bus.balanced;
   wire take_request = enable_rise &&
                       (phase == dram_array_pkg::PHASE_PRECHARGE);
   wire picked_bit   = bus.restored[column_address_bits];
   wire refresh_wrap =
      (refresh_timer == REFRESH_LIMIT[dram_array_pkg::REFRESH_WIDTH-1:0]);
   wire [dram_array_pkg::ROW_COUNT-1:0] row_onehot =
      {{(dram_array_pkg::ROW_COUNT-1){1'b0}}, 1'b1} << active_row;
   wire [dram_array_pkg::ROW_COUNT-1:0] rows_now =
      restore_now ? (rows_seen | row_onehot) : rows_seen;

   // Sense bank steering; the row is presented as soon as it opens
   assign bus.row_bits = cells[active_row];
   assign bus.column   = column_address_bits;
   assign bus.write_en = writing && selected;
   assign bus.data_in  = data_in;
   assign bus.equalize = !chip_enable;
   assign bus.strobe   = (phase == dram_array_pkg::PHASE_SENSE);

   // ************************************************************
   // Phase sequencing
   // ************************************************************
   // A fall of chip-enable wins before the restore phase, so a truncated access there
   // leaves the cells as they were; a fall during restore still writes the row back
   always_comb begin
      next_phase = phase;
      case (phase)
         dram_array_pkg::PHASE_PRECHARGE: begin
            if (enable_rise) begin
               next_phase = dram_array_pkg::PHASE_SHARE;
            end
         end
         dram_array_pkg::PHASE_SHARE: begin
            if (!chip_enable) begin
               next_phase = dram_array_pkg::PHASE_PRECHARGE;
            end else if (share_done) begin
               next_phase = dram_array_pkg::PHASE_SENSE;
            end
         end
         dram_array_pkg::PHASE_SENSE: begin
            if (!chip_enable) begin
               next_phase = dram_array_pkg::PHASE_PRECHARGE;
            end else begin
               next_phase = dram_array_pkg::PHASE_RESTORE;
            end
         end
         dram_array_pkg::PHASE_RESTORE: begin
            next_phase = chip_enable ? dram_array_pkg::PHASE_HOLD
                                     : dram_array_pkg::PHASE_PRECHARGE;
         end
         dram_array_pkg::PHASE_HOLD: begin
            if (!chip_enable) begin
               next_phase = dram_array_pkg::PHASE_PRECHARGE;
            end
         end
         default: begin
            next_phase = dram_array_pkg::PHASE_PRECHARGE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         phase       <= dram_array_pkg::PHASE_PRECHARGE;
         enable_prev <= 1'b0;
      end else begin
         phase       <= next_phase;
         enable_prev <= chip_enable;
      end
   end

   // Charge-share timer loaded on the rising edge of chip-enable
   always_ff @(posedge clock) begin
      if (rst) begin
         timer <= dram_array_pkg::TIMER_ZERO;
      end else if (enable_rise) begin
         timer <= dram_array_pkg::SHARE_CYCLES[
                  dram_array_pkg::TIMER_WIDTH-1:0];
      end else if (timer != dram_array_pkg::TIMER_ZERO) begin
         timer <= timer - dram_array_pkg::TIMER_ONE;
      end
   end

   // ************************************************************
   // Request capture
   // ************************************************************
   // Address, select and read-write are sampled once; later changes on those pins are ignored
   always_ff @(posedge clock) begin
      if (rst) begin
         row_address_bits    <= dram_array_pkg::ROW_ZERO;
         column_address_bits <= dram_array_pkg::COL_ZERO;
         selected            <= 1'b0;
         writing             <= 1'b0;
      end else if (take_request) begin
         row_address_bits    <= take_row;
         column_address_bits <= take_col;
         selected            <= chip_select;
         writing             <= !read_write;
      end
   end

   // ************************************************************
   // Cell array write-back
   // ************************************************************
   // Whole row goes back on every access that reaches restore, selected or not
   always_ff @(posedge clock) begin
      if (restore_now) begin
         cells[active_row] <= bus.restored;
      end
   end

   // ************************************************************
   // Output registers
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         data_out           <= 1'b0;
         data_valid         <= 1'b0;
         sense_latch_strobe <= 1'b0;
         precharging        <= 1'b1;
         active_row         <= dram_array_pkg::ROW_ZERO;
         dummy_half         <= 1'b0;
      end else begin
         sense_latch_strobe <= (next_phase == dram_array_pkg::PHASE_SENSE);
         precharging        <= !chip_enable;
         if (enable_rise && phase == dram_array_pkg::PHASE_PRECHARGE) begin
            active_row <= take_row;
            dummy_half <= !take_row[dram_array_pkg::HALF_BIT];
         end
         // Output buffer holds the bit until chip-enable falls
         if (!chip_enable) begin
            data_valid <= 1'b0;
            data_out   <= 1'b0;
         end else if (restore_now && selected && !writing) begin
            data_valid <= 1'b1;
            data_out   <= picked_bit;
         end
      end
   end

   // ************************************************************
   // Controller timing watch
   // ************************************************************
   // Flags a cycle ended before the least full cycle time; sticky
   always_ff @(posedge clock) begin
      if (rst) begin
         cycle_age   <= dram_array_pkg::TIMER_ZERO;
         short_cycle <= 1'b0;
      end else begin
         if (enable_rise) begin
            cycle_age <= dram_array_pkg::TIMER_ONE;
         end else if (cycle_age != dram_array_pkg::TIMER_ZERO &&
                      cycle_age != dram_array_pkg::CYCLE_CYCLES[
                                   dram_array_pkg::TIMER_WIDTH-1:0]) begin
            cycle_age <= cycle_age + dram_array_pkg::TIMER_ONE;
         end
         if (enable_rise && cycle_age != dram_array_pkg::TIMER_ZERO &&
             cycle_age != dram_array_pkg::CYCLE_CYCLES[
                          dram_array_pkg::TIMER_WIDTH-1:0]) begin
            short_cycle <= 1'b1;
         end
      end
   end

   // Every row must be restored once per refresh interval; sticky
   always_ff @(posedge clock) begin
      if (rst) begin
         refresh_timer  <= '0;
         rows_seen      <= dram_array_pkg::LINE_ZERO;
         refresh_missed <= 1'b0;
      end else begin
         if (refresh_wrap) begin
            refresh_timer <= '0;
            rows_seen     <= restore_now ? row_onehot
                                         : dram_array_pkg::LINE_ZERO;
            if (rows_now != dram_array_pkg::ALL_ROWS) begin
               refresh_missed <= 1'b1;
            end
         end else begin
            refresh_timer <= refresh_timer + 1'b1;
            rows_seen     <= rows_now;
         end
      end
   end

endmodule
`default_nettype wire

//--- test/dram_controller_model.sv
`default_nettype none
// ************************************************************
// Memory controller seen from the array pins
// ************************************************************
module dram_controller_model (
   input  wire logic        clock,
   input  wire logic        start,
   input  wire logic        cmd_read,
   input  wire logic        cmd_select,
   input  wire logic        cmd_short,
   input  wire logic        cmd_data,
   input  wire logic [11:0] cmd_addr,
   output var  logic        busy,
   output var  logic        chip_enable,
   output var  logic        chip_select,
   output var  logic        read_write,
   output var  logic [11:0] address,
   output var  logic        data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // One access per start; pins move just after an edge
   initial begin
      busy = 1'h0;
      chip_enable = 1'h0;
      chip_select = 1'h0;
      read_write = 1'h1;
      address = 12'h000;
      data_in = 1'h0;
      forever begin
         @(posedge clock);
         if (start) begin
            #1;
            busy = 1'h1;
            chip_enable = 1'h1;
            chip_select = cmd_select;
            read_write = cmd_read;
            address = cmd_addr;
            data_in = cmd_data;
            @(posedge clock);
            #1;
            // Registered at the rise, so show a stale value no longer
            address = ~address;
            chip_select = ~chip_select;
            read_write = ~read_write;
            repeat (4) @(posedge clock);
            #1;
            // Data-in stands through the strobe edge, then goes stale
            data_in = ~data_in;
            // Enable high for 300 ns unless a short cycle is asked
            repeat (cmd_short ? 0 : 7) @(posedge clock);
            #1;
            chip_enable = 1'h0;
            repeat (cmd_short ? 2 : 7) @(posedge clock);
            // Dropped on the edge so the bench reads it a step later
            busy = 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/dram_core_asserts.sv
`default_nettype none
module dram_core_asserts #(
   parameter int REFRESH_LIMIT = 200
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        chip_enable,
   input wire logic        chip_select,
   input wire logic        read_write,
   input wire logic [11:0] address,
   input wire logic        data_in,
   input wire logic        data_out,
   input wire logic        data_valid,
   input wire logic        sense_latch_strobe,
   input wire logic        precharging,
   input wire logic [5:0]  active_row,
   input wire logic        dummy_half,
   input wire logic        short_cycle,
   input wire logic        refresh_missed
);
   timeunit 1ns;
   timeprecision 100ps;
   logic ce_prev;
   logic rd_sel;
   logic rise;
   // An access opens where enable was low the edge before
   assign rise = chip_enable && !ce_prev;
   // Remember the kind of access each rise opened
   always_ff @(posedge clock) begin
      ce_prev <= rst ? 1'h0 : chip_enable;
      rd_sel <= rise ? (read_write && chip_select) : rd_sel;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_strobe_delay: assert property (
      rise ##1 chip_enable [*3] |=> ##[0:1] sense_latch_strobe)
      else $error("strobe missing after rise");
   chk_strobe_single: assert property (
      sense_latch_strobe |=> !sense_latch_strobe)
      else $error("strobe wider than one cycle");
   chk_strobe_cause: assert property (
      sense_latch_strobe |-> $past(rise, 4) || $past(rise, 5))
      else $error("strobe without a rise");
   chk_read_valid: assert property (
      rise && read_write && chip_select ##1 chip_enable [*6]
      |-> data_valid)
      else $error("read data not valid");
   chk_valid_kind: assert property (
      data_valid |-> rd_sel)
      else $error("data valid on write or deselect");
   chk_valid_drop: assert property (
      !chip_enable |=> !data_valid)
      else $error("data valid after enable low");
   chk_out_steady: assert property (
      data_valid && $past(data_valid) |-> $stable(data_out))
      else $error("data out moved while valid");
   chk_precharge_low: assert property (
      !chip_enable [*2] |-> precharging)
      else $error("no precharge with enable low");
   chk_precharge_high: assert property (
      chip_enable [*2] |-> !precharging)
      else $error("precharge during access");
   chk_row_open: assert property (
      rise ##1 chip_enable [*5] |-> active_row == $past(address[5:0], 5))
      else $error("wrong row opened");
   chk_dummy_side: assert property (
      rise ##1 chip_enable [*5] |-> dummy_half == !$past(address[5], 5))
      else $error("dummy row on wrong side");
endmodule
bind dynamic_ram_4k_array_core dram_core_asserts #(
   .REFRESH_LIMIT(REFRESH_LIMIT)
) chk (
   .clock(clock), .rst(rst), .chip_enable(chip_enable),
   .chip_select(chip_select), .read_write(read_write),
   .address(address), .data_in(data_in), .data_out(data_out),
   .data_valid(data_valid), .sense_latch_strobe(sense_latch_strobe),
   .precharging(precharging), .active_row(active_row),
   .dummy_half(dummy_half), .short_cycle(short_cycle),
   .refresh_missed(refresh_missed)
);
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIMIT = 5000;
   logic        clock, rst, start, cmd_read, cmd_select, cmd_short;
   logic        cmd_data, busy, chip_enable, chip_select, read_write;
   logic        data_in, data_out, data_valid, sense_latch_strobe;
   logic        precharging, dummy_half, short_cycle, refresh_missed;
   logic        dv_prev;
   logic [11:0] cmd_addr, address;
   logic [5:0]  active_row;
   logic        shadow [4096];
   logic        exp_q [$];
   logic [11:0] spots [$];
   int          bad_count, samples_checked, seed, i;
   dram_controller_model partner (
      .clock(clock), .start(start), .cmd_read(cmd_read),
      .cmd_select(cmd_select), .cmd_short(cmd_short),
      .cmd_data(cmd_data), .cmd_addr(cmd_addr), .busy(busy),
      .chip_enable(chip_enable), .chip_select(chip_select),
      .read_write(read_write), .address(address), .data_in(data_in)
   );
   dynamic_ram_4k_array_core #(.REFRESH_LIMIT(LIMIT)) uut (
      .clock(clock), .rst(rst), .chip_enable(chip_enable),
      .chip_select(chip_select), .read_write(read_write),
      .address(address), .data_in(data_in), .data_out(data_out),
      .data_valid(data_valid), .sense_latch_strobe(sense_latch_strobe),
      .precharging(precharging), .active_row(active_row),
      .dummy_half(dummy_half), .short_cycle(short_cycle),
      .refresh_missed(refresh_missed)
   );
   // ************************************************************
   // Clock, checks and accesses
   // ************************************************************
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Waits for the controller, notes the expected bit, then starts
   task automatic access(input logic rd, input logic sel,
                         input logic dat, input logic shrt,
                         input logic [11:0] adr);
      int n;
      @(posedge clock);
      #1;
      for (n = 0; n < 100 && busy; n++) begin
         @(posedge clock);
         #1;
      end
      if (busy) begin
         bad_count++;
         end_sim();
      end
      if (sel && rd) exp_q.push_back(shadow[adr]);
      if (sel && !rd) shadow[adr] = dat;
      cmd_read = rd;
      cmd_select = sel;
      cmd_data = dat;
      cmd_short = shrt;
      cmd_addr = adr;
      start = 1'h1;
      @(posedge clock);
      #1;
      start = 1'h0;
   endtask
   // Deselected accesses opening every row once, random columns
   task automatic sweep();
      for (int r = 0; r < 64; r++)
         access(1'h1, 1'h0, 1'h0, 1'h0, {6'($random(seed)), 6'(r)});
   endtask
   // Each first cycle of valid data takes the oldest note
   always @(posedge clock) begin
      dv_prev <= data_valid;
      if (data_valid === 1'h1 && dv_prev !== 1'h1) begin
         if (exp_q.size() == 0) check(1'h1, 1'h0);
         else check(data_out, exp_q.pop_front());
      end
   end
   initial begin
      seed = 47307;
      bad_count = 0;
      samples_checked = 0;
      rst = 1'h1;
      start = 1'h0;
      {cmd_read, cmd_select, cmd_short, cmd_data} = 4'h0;
      cmd_addr = 12'h000;
      repeat (10) @(posedge clock);
      #1;
      rst = 1'h0;
      check(precharging, 1'h1);
      check({data_valid, sense_latch_strobe, short_cycle}, 3'h0);
      $display("test reset done");
      sweep();
      // Corners of the row and column fields, then row 32 column 32, then random cells
      spots = '{12'h000, 12'hFFF, 12'h03F, 12'hFC0, 12'h820};
      repeat (8) spots.push_back(12'($random(seed)));
      foreach (spots[k]) access(1'h0, 1'h1, 1'($random(seed)), 1'h0, spots[k]);
      foreach (spots[k]) access(1'h1, 1'h1, 1'h0, 1'h0, spots[k]);
      // A deselected write must leave the cell as it was
      access(1'h0, 1'h0, ~shadow[0], 1'h0, 12'h000);
      access(1'h1, 1'h1, 1'h0, 1'h0, 12'h000);
      $display("test data done");
      for (i = 0; i < 4; i++) sweep();
      check(refresh_missed, 1'h0);
      check(short_cycle, 1'h0);
      for (i = 0; i < 3; i++) access(1'h1, 1'h0, 1'h0, 1'(i == 0), 12'h5A5);
      check(short_cycle, 1'h1);
      $display("test short cycle done");
      // Idle past a whole interval so some row goes unrefreshed
      repeat (2 * LIMIT + 50) @(posedge clock);
      check(refresh_missed, 1'h1);
      check(16'(exp_q.size()), 16'h0000);
      $display("test refresh done");
      end_sim();
   end
endmodule
`default_nettype wire
